// *** rtl/ssb_map.svh ***
// Register map, field positions and reset values of the safety status bank
// ==========================================================================
// Functional notes
// RULE_01: Capability bit 0: torque removal via terminals
// RULE_02: Capability bit 1: safe brake control available
// RULE_03: Capability bit 2: extended motion monitoring available
// RULE_04: Capability bit 3: controlled stop one available
// RULE_05: Capability is joint unit and module support
// RULE_06: Drive word bits 0,1,2,4,9,31 report status
// RULE_07: Drive word is AND of both channels
// RULE_08: Unit word bits 0,1,2,4,9,10,15 report status
`ifndef SSB_MAP_SVH
`define SSB_MAP_SVH

// ==========================================================================
// Byte offsets
`define SSB_OFS_CAPABILITY 4'h0
`define SSB_OFS_UNIT_STATUS 4'h4
`define SSB_OFS_DRIVE_STATUS 4'h8
`define SSB_OFS_IRQ_STATUS 4'hc
`define SSB_ADDR_W 4

// ==========================================================================
// Capability word fields
`define SSB_CAP_TORQUE 0
`define SSB_CAP_BRAKE 1
`define SSB_CAP_MOTION 2
`define SSB_CAP_STOP1 3

// ==========================================================================
// Status word fields
`define SSB_ST_TORQUE_SEL 0
`define SSB_ST_TORQUE_ACT 1
`define SSB_ST_STOP1_ACT 2
`define SSB_ST_BRAKE_REQ 4
`define SSB_ST_STOPA_NOACK 9
`define SSB_ST_STOPA_ACT 10
`define SSB_ST_STOPF_ACT 15
`define SSB_ST_PATH_TEST 31

// Bits that exist in each word; all others read zero
`define SSB_UNIT_MASK 32'h0000_8617
`define SSB_DRIVE_MASK 32'h8000_0217

// Interrupt mask register sits one word above the status register
`define SSB_OFS_IRQ_MASK 5'h10
`define SSB_IRQ_RESET 32'h0000_0000
`define SSB_RESP_OKAY 2'h0
`define SSB_RESP_SLVERR 2'h2

`endif

// *** rtl/ssb_pkg.sv ***
// Types shared by the safety status bank
package ssb_pkg;
  typedef logic [31:0] ssb_word_t;
  typedef logic [1:0] ssb_resp_t;
endpackage : ssb_pkg

// *** rtl/ssb_sync.sv ***
// Two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module ssb_sync #(
  parameter int W = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } ssb_sync_s;

  ssb_sync_s st_r;
  ssb_sync_s st_nxt;

  always_comb begin
    st_nxt.meta = d;
    st_nxt.sync = st_r.meta;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.sync;
endmodule : ssb_sync

// *** rtl/ssb_bank.sv ***
// Safety status word bank with AXI4-Lite register access and interrupt
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`include "ssb_map.svh"
`timescale 1ns/1ps
module ssb_bank (
  input wire logic aclk,
  input wire logic aresetn,
  // Support straps of control unit and power module
  input wire logic [3:0] unit_support,
  input wire logic [3:0] module_support,
  // Status from the unit and from the two monitoring channels
  input wire logic [31:0] unit_status,
  input wire logic [31:0] chan_a_status,
  input wire logic [31:0] chan_b_status,
  // AXI4-Lite slave
  input wire logic [`SSB_ADDR_W:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [`SSB_ADDR_W:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic irq
);
  // ========================================================================
  // Pin synchronisers
  logic [95:0] pins_sync;
  logic [7:0] sup_sync;

  ssb_sync #(.W(96)) u_sync_status (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({unit_status, chan_a_status, chan_b_status}),
    .q(pins_sync)
  );

  ssb_sync #(.W(8)) u_sync_support (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({unit_support, module_support}),
    .q(sup_sync)
  );

  // ========================================================================
  // State
  typedef struct packed {
    ssb_pkg::ssb_word_t cap;
    ssb_pkg::ssb_word_t unit;
    ssb_pkg::ssb_word_t drive;
    ssb_pkg::ssb_word_t irq_st;
    ssb_pkg::ssb_word_t irq_mask;
    logic aw_got;
    logic [`SSB_ADDR_W:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    ssb_pkg::ssb_resp_t bresp;
    logic rvalid;
    ssb_pkg::ssb_word_t rdata;
    ssb_pkg::ssb_resp_t rresp;
    logic irq;
  } ssb_bank_s;

  ssb_bank_s st_r;
  ssb_bank_s st_nxt;

  ssb_pkg::ssb_word_t unit_in;
  ssb_pkg::ssb_word_t drive_in;
  ssb_pkg::ssb_word_t cap_in;
  ssb_pkg::ssb_word_t events;
  ssb_pkg::ssb_word_t wclr;
  ssb_pkg::ssb_word_t wval;
  logic do_write;

  always_comb begin
    // Joint support: a function counts only if both parts carry it
    cap_in = '0;
    cap_in[`SSB_CAP_TORQUE] = sup_sync[4] & sup_sync[0]; // RULE_01 RULE_05
    cap_in[`SSB_CAP_BRAKE] = sup_sync[5] & sup_sync[1]; // RULE_02 RULE_05
    cap_in[`SSB_CAP_MOTION] = sup_sync[6] & sup_sync[2]; // RULE_03 RULE_05
    cap_in[`SSB_CAP_STOP1] = sup_sync[7] & sup_sync[3]; // RULE_04 RULE_05
    unit_in = pins_sync[95:64] & `SSB_UNIT_MASK; // RULE_08
    // Either channel alone cannot claim a state for the drive
    drive_in = pins_sync[63:32] & pins_sync[31:0]
               & `SSB_DRIVE_MASK; // RULE_06 RULE_07
    // Rising edges of drive status bits are the interrupt events
    events = drive_in & ~st_r.drive;
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.cap = cap_in;
    st_nxt.unit = unit_in;
    st_nxt.drive = drive_in;
    wclr = '0;
    wval = '0;
    do_write = 1'b0;

    // ======================================================================
    // Write channel: address and data taken in either order
    if (s_awvalid && !st_r.aw_got) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_addr = s_awaddr;
    end
    if (s_wvalid && !st_r.w_got) begin
      st_nxt.w_got = 1'b1;
      st_nxt.w_data = s_wdata;
      st_nxt.w_strb = s_wstrb;
    end
    if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
      do_write = 1'b1;
      for (int i = 0; i < 4; i++) begin
        wval[i*8 +: 8] = st_r.w_strb[i] ? st_r.w_data[i*8 +: 8] : 8'h00;
      end
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = `SSB_RESP_OKAY;
      unique case (st_r.aw_addr)
        {1'b0, `SSB_OFS_CAPABILITY},
        {1'b0, `SSB_OFS_UNIT_STATUS},
        {1'b0, `SSB_OFS_DRIVE_STATUS}: st_nxt.bresp = `SSB_RESP_SLVERR;
        {1'b0, `SSB_OFS_IRQ_STATUS}: wclr = wval;
        `SSB_OFS_IRQ_MASK: begin
          for (int i = 0; i < 4; i++) begin
            if (st_r.w_strb[i]) begin
              st_nxt.irq_mask[i*8 +: 8] = st_r.w_data[i*8 +: 8];
            end
          end
        end
        default: st_nxt.bresp = `SSB_RESP_SLVERR;
      endcase
    end
    if (st_r.bvalid && s_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // Sticky events: a set in the clearing cycle wins
    st_nxt.irq_st = (st_r.irq_st & ~wclr) | events;

    // ======================================================================
    // Read channel
    if (s_arvalid && !st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = `SSB_RESP_OKAY;
      unique case (s_araddr)
        {1'b0, `SSB_OFS_CAPABILITY}: st_nxt.rdata = st_r.cap;
        {1'b0, `SSB_OFS_UNIT_STATUS}: st_nxt.rdata = st_r.unit;
        {1'b0, `SSB_OFS_DRIVE_STATUS}: st_nxt.rdata = st_r.drive;
        {1'b0, `SSB_OFS_IRQ_STATUS}: st_nxt.rdata = st_r.irq_st;
        `SSB_OFS_IRQ_MASK: st_nxt.rdata = st_r.irq_mask;
        default: begin
          st_nxt.rdata = '0;
          st_nxt.rresp = `SSB_RESP_SLVERR;
        end
      endcase
    end else if (st_r.rvalid && s_rready) begin
      st_nxt.rvalid = 1'b0;
    end

    st_nxt.irq = |(st_nxt.irq_st & st_nxt.irq_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.irq_mask <= `SSB_IRQ_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ========================================================================
  // Outputs, all from flip-flops
  assign s_awready = !st_r.aw_got;
  assign s_wready = !st_r.w_got;
  assign s_bvalid = st_r.bvalid;
  assign s_bresp = st_r.bresp;
  assign s_arready = !st_r.rvalid;
  assign s_rvalid = st_r.rvalid;
  assign s_rdata = st_r.rdata;
  assign s_rresp = st_r.rresp;
  assign irq = st_r.irq;
endmodule : ssb_bank

// *** dv/ssb_bank_props.sv ***
// Read-path checker for the safety status bank
`timescale 1ns/1ps
module ssb_bank_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] unit_support,
  input wire logic [3:0] module_support,
  input wire logic [31:0] unit_status,
  input wire logic [31:0] chan_a_status,
  input wire logic [31:0] chan_b_status,
  input wire logic [4:0] s_araddr,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic s_rvalid
);
  // ==========
  // Helpers
  // Pins cross two sync stages, so a word is judged only after a quiet spell
  logic [2:0] quiet_r;
  logic [4:0] raddr_r;
  logic [31:0] ab;
  logic [3:0] cap;
  assign ab = chan_a_status & chan_b_status;
  assign cap = unit_support & module_support;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    if (aresetn && $stable({unit_support, module_support, unit_status, ab}))
      quiet_r <= quiet_r + {2'h0, quiet_r != 3'h7};
    else
      quiet_r <= 3'h0;
    if (s_arvalid && s_arready)
      raddr_r <= s_araddr;
  end
  sequence rd_word(logic [4:0] a);
    $rose(s_rvalid) && raddr_r == a && quiet_r == 3'h7;
  endsequence
  // ==========
  // Properties
  a_cap_torque: assert property (
    rd_word(5'h0) |-> s_rdata[0] == cap[0]) else $error("cap bit 0");
  a_cap_brake: assert property (
    rd_word(5'h0) |-> s_rdata[1] == cap[1]) else $error("cap bit 1");
  a_cap_motion: assert property (
    rd_word(5'h0) |-> s_rdata[2] == cap[2]) else $error("cap bit 2");
  a_cap_stop: assert property (
    rd_word(5'h0) |-> s_rdata[3] == cap[3]) else $error("cap bit 3");
  a_cap_joint: assert property (
    rd_word(5'h0) |-> s_rdata == {28'h0, cap}) else $error("cap word");
  a_drive_bits: assert property (
    rd_word(5'h8) |-> s_rdata == (ab & 32'h8000_0217))
    else $error("drive word");
  a_drive_and: assert property (
    rd_word(5'h8) |-> (s_rdata & ~ab) == 32'h0) else $error("drive and");
  a_unit_bits: assert property (
    rd_word(5'h4) |-> s_rdata == (unit_status & 32'h0000_8617))
    else $error("unit word");
endmodule : ssb_bank_props

// *** dv/ssb_bank_test.sv ***
// Self-checking bench for the safety status bank
`timescale 1ns/1ps
module ssb_bank_test;
  logic aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq;
  logic [3:0] unit_support, module_support, s_wstrb;
  logic [31:0] unit_status, chan_a_status, chan_b_status, s_wdata, s_rdata;
  logic [4:0] s_awaddr, s_araddr;
  logic [1:0] s_bresp, s_rresp;
  int err_count, comparisons;
  ssb_bank DUT (.aclk, .aresetn, .unit_support, .module_support,
    .unit_status, .chan_a_status, .chan_b_status, .s_awaddr, .s_awvalid,
    .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
    .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready, .irq);
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // ==========
  // Tasks
  task automatic check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  // Both tasks start on a fresh edge so back-to-back calls never collide
  task automatic rd(input logic [4:0] a, input logic [31:0] e,
    input logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 1'b0;
      n++;
    end while (!s_rvalid && n < 50);
    if (n >= 50) err_count++;
    s_rready <= 1'b0;
    check("read resp", {30'h0, s_rresp}, {30'h0, r});
    check("read data", s_rdata, e);
  endtask : rd
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
    input logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
      n++;
    end while (!s_bvalid && n < 50);
    if (n >= 50) err_count++;
    s_bready <= 1'b0;
    check("write resp", {30'h0, s_bresp}, {30'h0, r});
  endtask : wr
  // ==========
  // Tests
  initial begin
    {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {unit_support, module_support, unit_status, chan_a_status} = '0;
    {chan_b_status, s_wdata, s_awaddr, s_araddr} = '0;
    s_wstrb = 4'hf;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 256; i++) begin
      unit_support <= i[3:0];
      module_support <= i[7:4];
      repeat (8) @(posedge aclk);
      rd(5'h0, {28'h0, i[3:0] & i[7:4]}, 2'h0);
    end
    $display("test capability done");
    for (int k = 0; k < 33; k++) begin
      unit_status <= (k == 32) ? 32'hffff_ffff : 32'h1 << k;
      chan_a_status <= (32'h1 << k) | 32'h5555_5555;
      chan_b_status <= (32'h1 << k) | 32'haaaa_aaaa;
      repeat (8) @(posedge aclk);
      rd(5'h4, unit_status & 32'h0000_8617, 2'h0);
      rd(5'h8, (32'h1 << k) & 32'h8000_0217, 2'h0);
    end
    $display("test status words done");
    // The read-only capability word refuses writes and keeps its content
    wr(5'h0, 32'hffff_ffff, 2'h2);
    rd(5'h0, 32'h0000_000f, 2'h0);
    rd(5'h14, 32'h0, 2'h2);
    chan_a_status <= 32'h0;
    chan_b_status <= 32'h0;
    repeat (8) @(posedge aclk);
    wr(5'hc, 32'hffff_ffff, 2'h0);
    rd(5'hc, 32'h0, 2'h0);
    wr(5'h10, 32'h1, 2'h0);
    rd(5'h10, 32'h1, 2'h0);
    check("irq idle", {31'h0, irq}, 32'h0);
    chan_a_status <= 32'h1;
    chan_b_status <= 32'h1;
    repeat (8) @(posedge aclk);
    check("irq set", {31'h0, irq}, 32'h1);
    rd(5'hc, 32'h1, 2'h0);
    wr(5'h10, 32'h0, 2'h0);
    repeat (3) @(posedge aclk);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(5'h10, 32'h1, 2'h0);
    wr(5'hc, 32'h1, 2'h0);
    repeat (3) @(posedge aclk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    $display("test access and interrupt done");
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    print_verdict();
  end
endmodule : ssb_bank_test
bind ssb_bank ssb_bank_props u_props (.aclk, .aresetn, .unit_support,
  .module_support, .unit_status, .chan_a_status, .chan_b_status,
  .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rvalid);
